/* include/gais_pkg.sv */
// Constants and types shared by the port sampling and alternate select logic
package gais_pkg;

	// ==========================================================
	// Port geometry
	localparam int NUM_PORTS = 9;
	localparam int ALT_PORTS = 7;
	localparam int PORT_BITS = 8;
	localparam int PIN_W     = NUM_PORTS * PORT_BITS;
	localparam int ALT_W     = ALT_PORTS * PORT_BITS;
	localparam int PORT_C    = 2;
	localparam logic [3:0] NO_PORT = 4'hf;

	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam int IDX_W = 14;
	localparam logic [IDX_W-1:0] PIN_IDX [NUM_PORTS] = '{
		14'h0fd2, 14'h0fd6, 14'h0fda, 14'h0fde, 14'h0fe2,
		14'h0fe6, 14'h0fea, 14'h0fee, 14'h0fbe};
	localparam logic [IDX_W-1:0] SUB_ADDR_BASE = 14'h0f00;
	localparam logic [IDX_W-1:0] UNMAPPED_IDX  = 14'h3fff;

	// ==========================================================
	// Sub-addresses and fields
	localparam logic [7:0] SUB_FIRST  = 8'h07;
	localparam logic [7:0] SUB_SECOND = 8'h08;
	localparam int FIELD_LSB = 0;
	localparam logic [7:0] SELECT_RESET   = 8'h00;
	localparam logic [7:0] SUB_ADDR_RESET = 8'h00;
	localparam logic [NUM_PORTS-1:0] BONDED_ALL = 9'h1ff;

	// ==========================================================
	// Bus slave states
	typedef enum logic [0:0] {
		GAIS_IDLE = 1'b0,
		GAIS_WAIT = 1'b1
	} gais_state_t;

endpackage

/* logic/gais_sync2.sv */
// Two-stage synchroniser for asynchronous pin levels
module gais_sync2 #(
	parameter int WIDTH = 8
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	// ==========================================================
	// Stages
	logic [WIDTH-1:0] meta;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule

/* logic/gais_top.sv */
// Port alternate function select subregisters and pin input sampling
// ==========================================================
module gais_top
	import gais_pkg::*;
#(
	parameter logic [NUM_PORTS-1:0] BONDED = BONDED_ALL
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             hsel,
	input  wire logic [31:0]      haddr,
	input  wire logic [1:0]       htrans,
	input  wire logic             hwrite,
	input  wire logic [2:0]       hsize,
	input  wire logic [31:0]      hwdata,
	input  wire logic             hready,
	output logic      [31:0]      hrdata,
	output logic                  hreadyout,
	output logic                  hresp,
	input  wire logic [PIN_W-1:0] pin_level,
	input  wire logic [ALT_W-1:0] alt_enable,
	output logic      [ALT_W-1:0] alt_set_select_first,
	output logic      [7:0]       alt_set_select_second,
	output logic      [ALT_W-1:0] alt_route_first,
	output logic      [7:0]       alt_route_second
);

	// ==========================================================
	// Decoding
	function automatic logic [3:0] pin_port(input logic [IDX_W-1:0] idx);
		pin_port = NO_PORT;
		for (int i = 0; i < NUM_PORTS; i++) begin
			if (idx == PIN_IDX[i]) begin
				pin_port = 4'(i);
			end
		end
	endfunction

	// Address registers at even, control registers at odd indices
	function automatic logic [3:0] sub_port(input logic [IDX_W-1:0] idx,
		input logic ctrl);
		sub_port = NO_PORT;
		for (int i = 0; i < ALT_PORTS; i++) begin
			if (idx == SUB_ADDR_BASE + IDX_W'(2 * i) + IDX_W'(ctrl)) begin
				sub_port = 4'(i);
			end
		end
	endfunction

	// ==========================================================
	// Declarations
	gais_state_t      state;
	logic             wr_q;
	logic [IDX_W-1:0] idx_q;
	logic [7:0]       sub_addr [ALT_PORTS];
	logic [PIN_W-1:0] pin_sync;
	logic [31:0]      next_rdata;
	logic             accept;
	logic             wr_go;
	logic             rd_go;
	logic [3:0]       pin_hit;
	logic [3:0]       addr_hit;
	logic [3:0]       ctrl_hit;

	assign accept   = hsel && htrans[1] && hready && (state == GAIS_IDLE);
	assign wr_go    = (state == GAIS_WAIT) && wr_q;
	assign rd_go    = (state == GAIS_WAIT) && !wr_q;
	assign pin_hit  = pin_port(idx_q);
	assign addr_hit = sub_port(idx_q, 1'b0);
	assign ctrl_hit = sub_port(idx_q, 1'b1);

	// ==========================================================
	// Pin synchroniser
	gais_sync2 #(
		.WIDTH (PIN_W)
	) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.d       (pin_level),
		.q       (pin_sync)
	);

	// ==========================================================
	// Bus slave, one wait state per transfer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state     <= GAIS_IDLE;
			wr_q      <= 1'b0;
			idx_q     <= UNMAPPED_IDX;
			hreadyout <= 1'b1;
		end else if (accept) begin
			state     <= GAIS_WAIT;
			wr_q      <= hwrite;
			idx_q     <= (haddr[31:16] == 16'h0000) ? haddr[15:2] : UNMAPPED_IDX;
			hreadyout <= 1'b0;
		end else if (state == GAIS_WAIT) begin
			state     <= GAIS_IDLE;
			hreadyout <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	// ==========================================================
	// Read data
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (pin_hit != NO_PORT) begin
			if (BONDED[pin_hit]) begin
				next_rdata[7:0] =
					pin_sync[pin_hit*PORT_BITS +: PORT_BITS];
			end
		end else if (addr_hit != NO_PORT) begin
			next_rdata[7:0] = sub_addr[addr_hit[2:0]];
		end else if (ctrl_hit != NO_PORT) begin
			if (sub_addr[ctrl_hit[2:0]] == SUB_FIRST) begin
				next_rdata[7:0] =
					alt_set_select_first[ctrl_hit*PORT_BITS +: PORT_BITS];
			end else if (ctrl_hit == 4'(PORT_C) &&
				sub_addr[ctrl_hit[2:0]] == SUB_SECOND) begin
				next_rdata[7:0] = alt_set_select_second;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_go) begin
			hrdata <= next_rdata;
		end
	end

	// ==========================================================
	// Sub-address registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < ALT_PORTS; i++) begin
				sub_addr[i] <= SUB_ADDR_RESET;
			end
		end else if (wr_go && addr_hit != NO_PORT) begin
			sub_addr[addr_hit[2:0]] <= hwdata[7:0];
		end
	end

	// ==========================================================
	// Select subregisters; input data indices never match here
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			alt_set_select_first <= {ALT_PORTS{SELECT_RESET}};
		end else if (wr_go && ctrl_hit != NO_PORT &&
			sub_addr[ctrl_hit[2:0]] == SUB_FIRST) begin
			alt_set_select_first[ctrl_hit*PORT_BITS +: PORT_BITS] <=
				hwdata[FIELD_LSB +: PORT_BITS];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			alt_set_select_second <= SELECT_RESET;
		end else if (wr_go && ctrl_hit == 4'(PORT_C) &&
			sub_addr[PORT_C] == SUB_SECOND) begin
			alt_set_select_second <= hwdata[FIELD_LSB +: PORT_BITS];
		end
	end

	// ==========================================================
	// Routing gated by the alternate enables
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			alt_route_first  <= '0;
			alt_route_second <= 8'h00;
		end else begin
			alt_route_first  <= alt_set_select_first & alt_enable;
			alt_route_second <= alt_set_select_second &
				alt_enable[PORT_C*PORT_BITS +: PORT_BITS];
		end
	end

	// ==========================================================
	// Assertions
	generate
		for (genvar p = 0; p < ALT_PORTS; p++) begin : g_first_chk
			a_first_write: assert property (
				@(posedge hclk) disable iff (!hresetn)
				(wr_go && ctrl_hit == 4'(p) && sub_addr[p] == SUB_FIRST)
				|=> alt_set_select_first[p*PORT_BITS +: PORT_BITS]
					== $past(hwdata[7:0]))
			else $error("first select not written through control");

			a_first_other: assert property (
				@(posedge hclk) disable iff (!hresetn)
				!(wr_go && ctrl_hit == 4'(p) && sub_addr[p] == SUB_FIRST)
				|=> $stable(alt_set_select_first[p*PORT_BITS +: PORT_BITS]))
			else $error("first select changed without write");

			a_ctrl_read: assert property (
				@(posedge hclk) disable iff (!hresetn)
				(rd_go && ctrl_hit == 4'(p) && sub_addr[p] == SUB_FIRST)
				|=> hrdata[7:0] ==
					$past(alt_set_select_first[p*PORT_BITS +: PORT_BITS]))
			else $error("first select not read through control");

			a_addr_write: assert property (
				@(posedge hclk) disable iff (!hresetn)
				(wr_go && addr_hit == 4'(p))
				|=> sub_addr[p] == $past(hwdata[7:0]))
			else $error("sub-address not written");

			a_pin_ro_addr: assert property (
				@(posedge hclk) disable iff (!hresetn)
				(wr_go && pin_hit != NO_PORT) |=> $stable(sub_addr[p]))
			else $error("write to input data changed sub-address");
		end
	endgenerate

	generate
		for (genvar p = 0; p < NUM_PORTS; p++) begin : g_pin_chk
			if (BONDED[p]) begin : g_on
				a_pin_level: assert property (
					@(posedge hclk) disable iff (!hresetn)
					(rd_go && pin_hit == 4'(p))
					|=> hrdata[7:0] ==
						$past(pin_sync[p*PORT_BITS +: PORT_BITS]))
				else $error("input data differs from pin level");
			end
		end
	endgenerate

	a_first_reset: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$rose(hresetn) |-> (alt_set_select_first == '0 &&
			alt_set_select_second == 8'h00))
	else $error("select subregisters not clear after reset");

	a_route_gated: assert property (
		@(posedge hclk) disable iff (!hresetn)
		##1 ((alt_route_first & ~$past(alt_enable)) == '0 &&
		alt_route_first == $past(alt_set_select_first & alt_enable)))
	else $error("route not gated by enable");

	a_route_second: assert property (
		@(posedge hclk) disable iff (!hresetn)
		##1 (alt_route_second == $past(alt_set_select_second &
		alt_enable[PORT_C*PORT_BITS +: PORT_BITS])))
	else $error("second route not gated by enable");

	a_second_write: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(wr_go && ctrl_hit == 4'(PORT_C) && sub_addr[PORT_C] == SUB_SECOND)
		|=> alt_set_select_second == $past(hwdata[7:0]))
	else $error("second select not written");

	a_second_read: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(rd_go && ctrl_hit == 4'(PORT_C) && sub_addr[PORT_C] == SUB_SECOND)
		|=> hrdata[7:0] == $past(alt_set_select_second))
	else $error("second select not read through control");

	a_second_hold: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!(wr_go && ctrl_hit == 4'(PORT_C) && sub_addr[PORT_C] == SUB_SECOND)
		|=> $stable(alt_set_select_second))
	else $error("second select changed without write");

	a_pin_read: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(rd_go && pin_hit == 4'(PORT_C) && BONDED[PORT_C])
		|=> hrdata == {24'h000000,
			$past(pin_sync[PORT_C*PORT_BITS +: PORT_BITS])})
	else $error("input data read mismatch");

	a_pin_readonly: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(wr_go && pin_hit != NO_PORT)
		|=> ($stable(alt_set_select_first) && $stable(alt_set_select_second)))
	else $error("write to input data changed state");

	a_unbonded_zero: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(rd_go && pin_hit != NO_PORT && !BONDED[pin_hit])
		|=> hrdata == 32'h0000_0000)
	else $error("unbonded port read nonzero");

	a_sync_depth: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(hresetn && $past(hresetn) && $past(hresetn, 2))
		|-> pin_sync == $past(pin_level, 2))
	else $error("pin level not two cycles delayed");

	a_one_wait: assert property (
		@(posedge hclk) disable iff (!hresetn)
		accept |=> !hreadyout ##1 hreadyout)
	else $error("transfer not one wait state");

	// ==========================================================
	// Bus and read-back checks
	a_ctrl_other: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(rd_go && ctrl_hit != NO_PORT &&
			sub_addr[ctrl_hit[2:0]] != SUB_FIRST &&
			!(ctrl_hit == 4'(PORT_C) && sub_addr[PORT_C] == SUB_SECOND))
		|=> hrdata == 32'h0000_0000)
	else $error("control read with other sub-address nonzero");

	a_unmapped_zero: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(rd_go && pin_hit == NO_PORT && addr_hit == NO_PORT &&
			ctrl_hit == NO_PORT) |=> hrdata == 32'h0000_0000)
	else $error("unmapped read nonzero");

	a_rdata_upper: assert property (
		@(posedge hclk) disable iff (!hresetn)
		hrdata[31:8] == 24'h000000)
	else $error("read data upper bits nonzero");

	a_hresp_okay: assert property (
		@(posedge hclk) disable iff (!hresetn)
		hresp == 1'b0)
	else $error("response not okay");

	a_ready_idle: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(state == GAIS_IDLE && !accept) |=> hreadyout)
	else $error("slave not ready while idle");

	a_wait_state: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(state == GAIS_WAIT) |-> !hreadyout)
	else $error("slave ready during wait state");

endmodule

/* dv/gais_pins.sv */
// Model of the package pins that feed asynchronous levels to the ports
module gais_pins
	import gais_pkg::*;
(
	input  wire logic             hclk,
	input  wire logic [PIN_W-1:0] want,
	output logic      [PIN_W-1:0] pin_level
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Levels move off the clock edge, as a real pin would
	initial begin
		pin_level = '0;
		forever begin
			@(posedge hclk);
			pin_level <= #1 want;
		end
	end
endmodule

/* dv/tb.sv */
// Self-checking bench for port select subregisters and pin sampling
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import gais_pkg::*;
	logic             hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0]      haddr, hwdata, hrdata, seed, rd;
	logic [1:0]       htrans;
	logic [2:0]       hsize;
	logic [PIN_W-1:0] pin_level, pin_want;
	logic [ALT_W-1:0] alt_enable, sel1, rt1, exp1;
	logic [7:0]       sel2, rt2, v;
	int               n_mismatch, cmp_count;

	gais_top #(.BONDED(9'h0ff)) i_dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.pin_level(pin_level), .alt_enable(alt_enable),
		.alt_set_select_first(sel1), .alt_set_select_second(sel2),
		.alt_route_first(rt1), .alt_route_second(rt2));
	gais_pins i_pins (.hclk(hclk), .want(pin_want), .pin_level(pin_level));

	// ==========================================================
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction

	task automatic bus(input logic w, input logic [IDX_W-1:0] i,
		input logic [7:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {16'h0000, i, 2'b00};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= {24'h000000, d};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
		chk("hresp", 0, hresp);
	endtask

	task automatic sub(input int p, input logic [7:0] a, input logic w,
		input logic [7:0] d);
		bus(1'b1, SUB_ADDR_BASE + IDX_W'(2 * p), a);
		bus(w, SUB_ADDR_BASE + IDX_W'(2 * p + 1), d);
	endtask

	task automatic chk(input string n, input logic [ALT_W-1:0] e, g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	task print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ==========================================================
	// Clock and watchdog
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	initial begin
		repeat (20000) @(posedge hclk);
		n_mismatch++;
		print_verdict;
	end

	// ==========================================================
	// Tests
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		haddr = '0;
		hwdata = '0;
		pin_want = '0;
		alt_enable = '0;
		seed = 32'h00000005;
		exp1 = '0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		sub(0, SUB_FIRST, 1'b0, 8'h00);
		chk("first_reset", 0, rd);
		chk("second_reset", 0, sel2);
		for (int p = 0; p < ALT_PORTS; p++) begin
			seed = xs(seed);
			v = (p == 0) ? 8'hff : seed[7:0];
			sub(p, SUB_FIRST, 1'b1, v);
			exp1[p*8+:8] = v;
			sub(p, SUB_FIRST, 1'b0, 8'h00);
			chk("first_read", v, rd);
		end
		chk("first_out", exp1, sel1);
		$display("test select_first done");
		sub(PORT_C, SUB_SECOND, 1'b1, 8'ha5);
		sub(PORT_C, SUB_SECOND, 1'b0, 8'h00);
		chk("second_read", 8'ha5, rd);
		sub(0, SUB_SECOND, 1'b1, 8'h3c);
		sub(0, SUB_SECOND, 1'b0, 8'h00);
		chk("a_second", 0, rd);
		chk("second_out", 8'ha5, sel2);
		chk("first_kept", exp1, sel1);
		$display("test select_second done");
		seed = xs(seed);
		alt_enable <= {seed[23:0], xs(seed)};
		repeat (3) @(posedge hclk);
		chk("route_first", exp1 & alt_enable, rt1);
		chk("route_second", 8'ha5 & alt_enable[PORT_C*8+:8], rt2);
		$display("test routing done");
		for (int k = 0; k < 3; k++) begin
			seed = xs(seed);
			pin_want <= (k == 0) ? '1 : {seed[7:0], xs(seed), ~seed};
			repeat (4) @(posedge hclk);
			for (int p = 0; p < NUM_PORTS; p++) begin
				bus(1'b0, PIN_IDX[p], 8'h00);
				v = (p == 8) ? 8'h00 : pin_want[p*8+:8];
				chk("pin_read", v, rd);
			end
		end
		bus(1'b1, PIN_IDX[1], ~pin_want[15:8]);
		bus(1'b0, PIN_IDX[1], 8'h00);
		chk("pin_write", pin_want[15:8], rd);
		chk("pin_write_sel", exp1, sel1);
		$display("test pin_sample done");
		bus(1'b1, UNMAPPED_IDX, 8'hff);
		bus(1'b0, UNMAPPED_IDX, 8'h00);
		chk("unmapped", 0, rd);
		chk("unmapped_sel", 8'ha5, sel2);
		$display("test unmapped done");
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("first_cleared", 0, sel1);
		chk("second_cleared", 0, sel2);
		chk("route_cleared", 0, rt1);
		sub(PORT_C, SUB_SECOND, 1'b0, 8'h00);
		chk("second_read_cleared", 0, rd);
		$display("test reset done");
		print_verdict;
	end
endmodule
